// >>> rtl/sfd_consts.svh
// Purpose: Command codes, address lengths and sizes for the flash command decoder
// Assumes: Codes are the first byte sent after chip select falls
// Notes:   Included by bare name
`ifndef SFD_CONSTS_SVH
`define SFD_CONSTS_SVH

`define SFD_CMD_RESUME        8'h7a
`define SFD_CMD_RESUME_ALT1   8'h8a
`define SFD_CMD_RESUME_ALT2   8'h30
`define SFD_CMD_SUSPEND       8'h75
`define SFD_CMD_OTP_PGM       8'h42
`define SFD_CMD_OTP_RD        8'h4b
`define SFD_CMD_LOCK_RD3      8'hfa
`define SFD_CMD_LOCK_RD4      8'he0
`define SFD_CMD_LOCK_WR3      8'hfb
`define SFD_CMD_LOCK_WR4      8'he1
`define SFD_CMD_SCHEME_WR     8'h2f
`define SFD_CMD_QREAD3        8'h6b
`define SFD_CMD_QREAD4        8'h6c
`define SFD_WREN_DEFAULT      8'h06

`define SFD_ADDR_BYTES3       3'h3
`define SFD_ADDR_BYTES4       3'h4
`define SFD_SCHEME_BYTES      3'h2
`define SFD_OTP_BYTES         1024
`define SFD_OTP_AW            10
`define SFD_FIFO_DEPTH        4
`define SFD_SCK_MAX_MHZ       166
`define SFD_OUT_WAIT_MAX      40

`endif

// >>> rtl/sfd_pkg.sv
// Purpose: Types shared by the flash command decoder and its bench
// Assumes: Nothing
// Notes:   Constants live in sfd_consts.svh
package sfd_pkg;

  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DATA_IN, ST_DATA_OUT, ST_IGNORE} sfd_state_type;

  typedef enum logic [2:0] {
    OP_NONE, OP_OTP_PGM, OP_OTP_RD, OP_LOCK_RD, OP_LOCK_WR, OP_ARRAY_RD, OP_SCHEME_WR
  } sfd_op_type;

  typedef struct packed {
    sfd_op_type  kind;
    logic [31:0] addr;
  } sfd_rd_req_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
  } sfd_lock_wr_type;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } sfd_otp_wr_type;

  // Whole register state of the decoder
  typedef struct packed {
    logic            sck_s1;
    logic            sck_s2;
    logic            sck_s3;
    logic            cs_s1;
    logic            cs_s2;
    logic            cs_s3;
    logic            si_s1;
    logic            si_s2;
    sfd_state_type   st;
    sfd_op_type      kind;
    logic [7:0]      cmd;
    logic [2:0]      bitcnt;
    logic [2:0]      bytecnt;
    logic [7:0]      shin;
    logic [31:0]     addr;
    logic [2:0]      outcnt;
    logic [7:0]      outsh;
    logic [7:0]      scheme_lo;
    logic            wel;
    logic            suspended;
    logic            resume;
    logic            suspend;
    logic            rd_req;
    sfd_rd_req_type  rd;
    logic            lock_v;
    sfd_lock_wr_type lock;
    logic            scheme_v;
    logic [15:0]     scheme;
    logic            push_v;
    sfd_otp_wr_type  push;
    logic            buf_ready;
    logic [3:0]      dq;
    logic [3:0]      oe;
  } sfd_state_struct_type;

endpackage

// >>> rtl/sfd_fifo.sv
// Purpose: Small flop FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Full and empty are registered flags
`timescale 1ns/1ps
module sfd_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    full;
    logic                    nonempty;
  } sfd_fifo_state_type;

  sfd_fifo_state_type q;
  sfd_fifo_state_type d;
  logic               push;
  logic               pop;

  assign in_ready  = ~q.full;
  assign out_valid = q.nonempty;
  assign out_data  = q.mem[q.rp];

  always_comb
  begin
    d    = q;
    push = in_valid & ~q.full;
    pop  = out_ready & q.nonempty;
    if (push)
    begin
      d.mem[q.wp] = in_data;
      d.wp        = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop)
      d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    if (push && !pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      d.cnt = q.cnt - 1'b1;
    d.full     = (d.cnt == CW'(DEPTH));
    d.nonempty = (d.cnt != '0);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    (q.cnt <= CW'(DEPTH)) && (q.full == (q.cnt == CW'(DEPTH))))
    else $error("fifo count out of range");
endmodule

// >>> rtl/sfd_decoder.sv
// Purpose: Serial flash command decoder for resume/suspend, OTP, protection and quad read
// Assumes: Serial pins are asynchronous to clk and sampled here; sck well below clk/4
// Notes:   Read data comes from the array side on rd_data after each rd_req
`timescale 1ns/1ps
`include "sfd_consts.svh"

// How it works
// - Command 7A alone resumes a suspended program, erase or integrity check.
// - Commands 8A and 30 are taken as resume requests as well.
// - Command 42, an address and a stream of bytes programs the 1024-byte OTP region.
// - The OTP program address is three or four bytes by the active address length.
// - Command 4B with a three- or four-byte address streams OTP data from that address.
// - Command FA (three-byte) or E0 (four-byte) returns the sector volatile lock byte.
// - After write enable, FB (three-byte) or E1 (four-byte) plus one byte writes the lock.
// - Command 6B (three-byte) or 6C (four-byte) streams array data on four lines.
// - Command 75 suspends an ongoing operation so a resume can continue it.
module sfd_decoder #(
  parameter logic [7:0] WREN_CMD = `SFD_WREN_DEFAULT,
  parameter int         DEPTH    = `SFD_FIFO_DEPTH
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    sck,
  input  wire logic                    cs_n,
  input  wire logic                    si,
  output logic [3:0]                   dq_o,
  output logic [3:0]                   dq_oe,
  input  wire logic                    addr_4byte,
  input  wire logic                    op_busy,
  output logic                         resume_op,
  output logic                         suspend_op,
  output logic                         op_suspended,
  output logic                         write_enabled,
  output logic                         rd_req,
  output sfd_pkg::sfd_rd_req_type      rd_info,
  input  wire logic [7:0]              rd_data,
  output logic                         lock_wr_valid,
  output sfd_pkg::sfd_lock_wr_type     lock_wr,
  output logic                         scheme_wr_valid,
  output logic [15:0]                  scheme_value,
  output logic                         otp_wr_valid,
  input  wire logic                    otp_wr_ready,
  output sfd_pkg::sfd_otp_wr_type      otp_wr,
  output logic                         otp_buf_ready
);
  localparam int OUT_WAIT_MAX = `SFD_OUT_WAIT_MAX;
  sfd_pkg::sfd_state_struct_type q;
  sfd_pkg::sfd_state_struct_type d;
  logic                          fifo_in_ready;
  logic                          rise;
  logic                          fall;
  logic                          cs_act;
  logic                          cs_end;
  logic                          byte_done;
  logic [7:0]                    nb;
  logic [7:0]                    cur;
  logic [2:0]                    alen;

  sfd_fifo #(
    .W     ($bits(sfd_pkg::sfd_otp_wr_type)),
    .DEPTH (DEPTH)
  ) u_otp_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (q.push_v),
    .in_ready  (fifo_in_ready),
    .in_data   (q.push),
    .out_valid (otp_wr_valid),
    .out_ready (otp_wr_ready),
    .out_data  (otp_wr)
  );

  always_comb
  begin
    d          = q;
    cur        = q.outsh;
    d.resume   = 1'b0;
    d.suspend  = 1'b0;
    d.rd_req   = 1'b0;
    d.lock_v   = 1'b0;
    d.scheme_v = 1'b0;
    d.push_v   = 1'b0;
    d.buf_ready = fifo_in_ready;
    d.sck_s1   = sck;
    d.sck_s2   = q.sck_s1;
    d.sck_s3   = q.sck_s2;
    d.cs_s1    = cs_n;
    d.cs_s2    = q.cs_s1;
    d.cs_s3    = q.cs_s2;
    d.si_s1    = si;
    d.si_s2    = q.si_s1;
    rise       = q.sck_s2 & ~q.sck_s3;
    fall       = ~q.sck_s2 & q.sck_s3;
    cs_act     = ~q.cs_s2;
    cs_end     = q.cs_s2 & ~q.cs_s3;
    nb         = {q.shin[6:0], q.si_s2};
    byte_done  = cs_act & rise & (q.bitcnt == 3'h7);
    alen       = addr_4byte ? `SFD_ADDR_BYTES4 : `SFD_ADDR_BYTES3;
    if (cs_end)
    begin
      if (q.kind == sfd_pkg::OP_OTP_PGM && q.st == sfd_pkg::ST_DATA_IN)
        d.wel = 1'b0;
      d.st     = sfd_pkg::ST_CMD;
      d.kind   = sfd_pkg::OP_NONE;
      d.bitcnt = '0;
      d.oe     = '0;
    end
    else if (cs_act)
    begin
      if (rise)
      begin
        d.shin   = nb;
        d.bitcnt = q.bitcnt + 1'b1;
      end
      if (byte_done)
      begin
        case (q.st)
          sfd_pkg::ST_CMD:
          begin
            d.cmd     = nb;
            d.addr    = '0;
            d.st      = sfd_pkg::ST_IGNORE;
            d.bytecnt = alen;
            case (nb)
              `SFD_CMD_RESUME, `SFD_CMD_RESUME_ALT1, `SFD_CMD_RESUME_ALT2:
                if (q.suspended)
                begin
                  d.resume    = 1'b1;
                  d.suspended = 1'b0;
                end
              `SFD_CMD_SUSPEND:
                if (op_busy && !q.suspended)
                begin
                  d.suspend   = 1'b1;
                  d.suspended = 1'b1;
                end
              `SFD_CMD_OTP_PGM:
                if (q.wel)
                begin
                  d.st   = sfd_pkg::ST_ADDR;
                  d.kind = sfd_pkg::OP_OTP_PGM;
                end
              `SFD_CMD_OTP_RD:
              begin
                d.st   = sfd_pkg::ST_ADDR;
                d.kind = sfd_pkg::OP_OTP_RD;
              end
              `SFD_CMD_LOCK_RD3, `SFD_CMD_LOCK_RD4:
              begin
                d.st      = sfd_pkg::ST_ADDR;
                d.kind    = sfd_pkg::OP_LOCK_RD;
                d.bytecnt = (nb == `SFD_CMD_LOCK_RD4) ? `SFD_ADDR_BYTES4 : `SFD_ADDR_BYTES3;
              end
              `SFD_CMD_LOCK_WR3, `SFD_CMD_LOCK_WR4:
                if (q.wel)
                begin
                  d.st      = sfd_pkg::ST_ADDR;
                  d.kind    = sfd_pkg::OP_LOCK_WR;
                  d.bytecnt = (nb == `SFD_CMD_LOCK_WR4) ? `SFD_ADDR_BYTES4 : `SFD_ADDR_BYTES3;
                end
              `SFD_CMD_QREAD3, `SFD_CMD_QREAD4:
              begin
                d.st      = sfd_pkg::ST_ADDR;
                d.kind    = sfd_pkg::OP_ARRAY_RD;
                d.bytecnt = (nb == `SFD_CMD_QREAD4) ? `SFD_ADDR_BYTES4 : `SFD_ADDR_BYTES3;
              end
              `SFD_CMD_SCHEME_WR:
                if (q.wel)
                begin
                  d.st      = sfd_pkg::ST_DATA_IN;
                  d.kind    = sfd_pkg::OP_SCHEME_WR;
                  d.bytecnt = `SFD_SCHEME_BYTES;
                end
              default:
                if (nb == WREN_CMD)
                  d.wel = 1'b1;
            endcase
          end
          sfd_pkg::ST_ADDR:
          begin
            d.addr    = {q.addr[23:0], nb};
            d.bytecnt = q.bytecnt - 1'b1;
            if (q.bytecnt == 3'h1)
            begin
              if (q.kind == sfd_pkg::OP_OTP_PGM || q.kind == sfd_pkg::OP_LOCK_WR)
                d.st = sfd_pkg::ST_DATA_IN;
              else
              begin
                d.st      = sfd_pkg::ST_DATA_OUT;
                d.outcnt  = '0;
                d.rd_req  = 1'b1;
                d.rd.kind = q.kind;
                d.rd.addr = {q.addr[23:0], nb};
              end
            end
          end
          sfd_pkg::ST_DATA_IN:
          begin
            case (q.kind)
              sfd_pkg::OP_OTP_PGM:
              begin
                d.push_v    = fifo_in_ready;
                d.push.addr = q.addr[`SFD_OTP_AW-1:0];
                d.push.data = nb;
                d.addr      = q.addr + 32'h1;
              end
              sfd_pkg::OP_LOCK_WR:
              begin
                d.lock_v    = 1'b1;
                d.lock.addr = q.addr;
                d.lock.data = nb;
                d.wel       = 1'b0;
                d.st        = sfd_pkg::ST_IGNORE;
              end
              default:
              begin
                d.bytecnt = q.bytecnt - 1'b1;
                if (q.bytecnt == `SFD_SCHEME_BYTES)
                  d.scheme_lo = nb;
                else
                begin
                  d.scheme_v = 1'b1;
                  d.scheme   = {nb, q.scheme_lo};
                  d.wel      = 1'b0;
                  d.st       = sfd_pkg::ST_IGNORE;
                end
              end
            endcase
          end
          default:
            d.st = q.st;
        endcase
      end
      if (fall && q.st == sfd_pkg::ST_DATA_OUT)
      begin
        if (q.outcnt == 3'h0)
        begin
          cur       = rd_data;
          d.rd_req  = 1'b1;
          d.rd.addr = q.rd.addr + 32'h1;
        end
        if (q.kind == sfd_pkg::OP_ARRAY_RD)
        begin
          d.dq     = cur[7:4];
          d.oe     = 4'hf;
          d.outsh  = {cur[3:0], 4'h0};
          d.outcnt = (q.outcnt == 3'h1) ? 3'h0 : 3'h1;
        end
        else
        begin
          d.dq     = {2'h0, cur[7], 1'h0};
          d.oe     = 4'h2;
          d.outsh  = {cur[6:0], 1'h0};
          d.outcnt = q.outcnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q        <= '0;
      q.sck_s1 <= 1'b0;
      q.cs_s1  <= 1'b1;
      q.cs_s2  <= 1'b1;
      q.cs_s3  <= 1'b1;
    end
    else
      q <= d;
  end

  assign dq_o            = q.dq;
  assign dq_oe           = q.oe;
  assign resume_op       = q.resume;
  assign suspend_op      = q.suspend;
  assign op_suspended    = q.suspended;
  assign write_enabled   = q.wel;
  assign rd_req          = q.rd_req;
  assign rd_info         = q.rd;
  assign lock_wr_valid   = q.lock_v;
  assign lock_wr         = q.lock;
  assign scheme_wr_valid = q.scheme_v;
  assign scheme_value    = q.scheme;
  assign otp_buf_ready   = q.buf_ready;

  sequence sq_quad_start;
    q.rd_req && (q.rd.kind == sfd_pkg::OP_ARRAY_RD) && (q.st == sfd_pkg::ST_DATA_OUT);
  endsequence

  sequence sq_resume_seen;
    q.resume && (q.cmd inside {`SFD_CMD_RESUME, `SFD_CMD_RESUME_ALT1, `SFD_CMD_RESUME_ALT2});
  endsequence

  AST_RESUME_CODE: assert property (@(posedge clk) disable iff (!rst_n)
    q.resume |-> sq_resume_seen)
    else $error("resume pulse without resume code");
  AST_RESUME_ONLY_SUSPENDED: assert property (@(posedge clk) disable iff (!rst_n)
    q.resume |-> ($past(q.suspended) && !q.suspended))
    else $error("resume with nothing suspended");
  AST_RESUME_ALT: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(byte_done) && $past(q.st) == sfd_pkg::ST_CMD && $past(q.suspended)
     && q.cmd inside {`SFD_CMD_RESUME_ALT1, `SFD_CMD_RESUME_ALT2}) |-> q.resume)
    else $error("alternate resume code not taken");
  AST_SUSPEND: assert property (@(posedge clk) disable iff (!rst_n)
    q.suspend |-> (q.cmd == `SFD_CMD_SUSPEND) && q.suspended && !$past(q.suspended))
    else $error("suspend pulse without suspend code");
  AST_OTP_PUSH: assert property (@(posedge clk) disable iff (!rst_n)
    q.push_v |-> (q.cmd == `SFD_CMD_OTP_PGM) && q.wel && (q.st == sfd_pkg::ST_DATA_IN))
    else $error("otp byte queued outside otp program");
  AST_OTP_RD: assert property (@(posedge clk) disable iff (!rst_n)
    (q.rd_req && q.rd.kind == sfd_pkg::OP_OTP_RD) |-> (q.cmd == `SFD_CMD_OTP_RD))
    else $error("otp read request without otp read code");
  AST_LOCK_RD_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(q.st == sfd_pkg::ST_DATA_OUT) && q.cmd == `SFD_CMD_LOCK_RD3)
    |-> (q.rd.addr[31:24] == 8'h00))
    else $error("three-byte lock read took four address bytes");
  AST_LOCK_WR: assert property (@(posedge clk) disable iff (!rst_n)
    q.lock_v |-> $past(q.wel) && !q.wel
    && (q.cmd inside {`SFD_CMD_LOCK_WR3, `SFD_CMD_LOCK_WR4}))
    else $error("lock write without write enable or code");
  AST_QUAD_OUT: assert property (@(posedge clk) disable iff (!rst_n)
    sq_quad_start |-> ##[1:OUT_WAIT_MAX] ((q.oe == 4'hf) || (q.st == sfd_pkg::ST_CMD)))
    else $error("quad read did not drive four lines");
  AST_SCHEME_WR: assert property (@(posedge clk) disable iff (!rst_n)
    q.scheme_v |-> (q.cmd == `SFD_CMD_SCHEME_WR) && $past(q.wel)
    && (q.scheme[7:0] == q.scheme_lo))
    else $error("scheme write malformed");
  AST_OTP_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(q.st == sfd_pkg::ST_DATA_IN) && q.kind == sfd_pkg::OP_OTP_PGM && !addr_4byte)
    |-> (q.addr[31:24] == 8'h00))
    else $error("otp program address length wrong");
endmodule

// >>> bench/sfd_host.sv
// Purpose: Behavioural SPI host that frames commands for the flash command decoder
// Assumes: Mode 0 link clock, low between frames, one command per chip-select frame
// Notes:   The data line shows the inverse of its last bit while the host reads, and the last bit itself between frames
`timescale 1ns/1ps
module sfd_host #(
  parameter int HALF = 32
) (
  output logic             sck,
  output logic             cs_n,
  output logic             si,
  input  wire logic [3:0]  dq_o,
  input  wire logic [3:0]  dq_oe
);
  logic [7:0] rx [16];
  logic [3:0] oe_seen;

  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    oe_seen = 4'h0;
  end

  // Sends n_tx bytes, then collects n_rx bytes on one or four lines
  task automatic frame(input logic [7:0] tx [16], input int n_tx, input int n_rx,
                       input bit quad);
    logic [7:0] b;
    int         slots;
    // Link edges fall between clock edges, never on them
    #1.25 cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < n_tx; i++)
      for (int j = 7; j >= 0; j--)
      begin
        si = tx[i][j];
        #HALF sck = 1'b1;
        #HALF sck = 1'b0;
      end
    si = ~si;
    slots = quad ? 2 : 8;
    for (int i = 0; i < n_rx; i++)
    begin
      b = 8'h00;
      for (int j = 0; j < slots; j++)
      begin
        #HALF sck = 1'b1;
        b = quad ? {b[3:0], dq_o} : {b[6:0], dq_o[1]};
        oe_seen = dq_oe;
        #HALF sck = 1'b0;
      end
      rx[i] = b;
    end
    #HALF cs_n = 1'b1;
    si = ~si;
    #(2*HALF);
  endtask
endmodule

// >>> bench/sfd_decoder_test.sv
// Purpose: Self-checking bench for the flash command decoder
// Assumes: Host model drives the link at a 64 ns period; array side modelled here
// Notes:   Reset, then command table, then a second reset, read, and OTP program cases
`timescale 1ns/1ps
module sfd_decoder_test;
  typedef struct {
    logic        wren;
    int          n;
    logic [79:0] bytes;
    logic [3:0]  pulses;
    logic        we_after;
    logic        susp_after;
    logic [39:0] val;
  } sfd_row_type;

  logic                     clk, rst_n, sck, cs_n, si, addr_4byte, op_busy;
  logic [3:0]               dq_o, dq_oe, seen;
  logic                     resume_op, suspend_op, op_suspended, write_enabled, rd_req;
  sfd_pkg::sfd_rd_req_type  rd_info;
  logic [7:0]               rd_data;
  logic                     lock_wr_valid, scheme_wr_valid, otp_wr_valid, otp_wr_ready;
  sfd_pkg::sfd_lock_wr_type lock_wr;
  logic [15:0]              scheme_value;
  sfd_pkg::sfd_otp_wr_type  otp_wr;
  logic                     otp_buf_ready, clr;
  int                       n_errors, checks_done;
  sfd_row_type              rows [15];

  sfd_decoder i_dut (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .dq_o(dq_o), .dq_oe(dq_oe),
    .addr_4byte(addr_4byte), .op_busy(op_busy), .resume_op(resume_op),
    .suspend_op(suspend_op), .op_suspended(op_suspended), .write_enabled(write_enabled),
    .rd_req(rd_req), .rd_info(rd_info), .rd_data(rd_data), .lock_wr_valid(lock_wr_valid),
    .lock_wr(lock_wr), .scheme_wr_valid(scheme_wr_valid), .scheme_value(scheme_value),
    .otp_wr_valid(otp_wr_valid), .otp_wr_ready(otp_wr_ready), .otp_wr(otp_wr),
    .otp_buf_ready(otp_buf_ready)
  );

  sfd_host i_host (.sck(sck), .cs_n(cs_n), .si(si), .dq_o(dq_o), .dq_oe(dq_oe));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] fmem(input logic [2:0] k, input logic [31:0] a);
    return a[7:0] ^ {a[14:8], a[15]} ^ {a[21:16], a[23:22]} ^ {a[28:24], a[31:29]} ^ {k, 5'h15};
  endfunction

  // Array side answers each fetch one cycle later and holds until the next
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      rd_data <= 8'h00;
    else if (rd_req)
      rd_data <= fmem(rd_info.kind, rd_info.addr);

  // Pulses seen since the last clear: resume, suspend, lock write, scheme write
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      seen <= 4'h0;
    else
      seen <= clr ? 4'h0 : seen | {resume_op, suspend_op, lock_wr_valid, scheme_wr_valid};

  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic send(input logic [79:0] bytes, input int n, input int nrx, input bit quad);
    logic [7:0] tx [16];
    for (int i = 0; i < n; i++)
      tx[i] = bytes[8*(n-1-i) +: 8];
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    i_host.frame(tx, n, nrx, quad);
    repeat (8) @(posedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk) rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("idle outputs", 40'h0, 40'({resume_op, suspend_op, op_suspended, write_enabled,
          rd_req, lock_wr_valid, scheme_wr_valid, otp_wr_valid, dq_oe}));
    $display("Reset case done");
  endtask

  task automatic rd_test(input logic [79:0] bytes, input int n, input int nrx, input bit quad,
                         input logic [2:0] kind, input logic [31:0] addr);
    send(bytes, n, nrx, quad);
    for (int i = 0; i < nrx; i++)
      check("read byte", 40'(fmem(kind, addr + i)), 40'(i_host.rx[i]));
    check("read lines", 40'(quad ? 4'hf : 4'h2), 40'(i_host.oe_seen));
    check("read kind", 40'(kind), 40'(rd_info.kind));
    check("lines released", 40'h0, 40'(dq_oe));
    $display("Read %h done", bytes[8*(n-1) +: 8]);
  endtask

  task automatic otp_test(input logic [79:0] bytes, input int n, input logic [9:0] base,
                          input int nexp, input logic [31:0] dat);
    int got;
    got = 0;
    send(80'h06, 1, 0, 1'b0);
    @(posedge clk) otp_wr_ready <= 1'b0;
    send(bytes, n, 0, 1'b0);
    check("buffer room", 40'(nexp < 4), 40'(otp_buf_ready));
    check("write_enabled", 40'h0, 40'(write_enabled));
    @(posedge clk) otp_wr_ready <= 1'b1;
    for (int c = 0; c < 40 && got < 5; c++)
    begin
      @(posedge clk);
      if (otp_wr_valid === 1'b1 && otp_wr_ready === 1'b1)
      begin
        if (got < nexp)
          check("otp word", {22'h0, 10'(base + got), dat[31-8*got -: 8]}, 40'(otp_wr));
        got++;
      end
    end
    check("otp count", 40'(nexp), 40'(got));
    $display("OTP program done");
  endtask

  initial
  begin
    rows = '{
      '{1'b0, 1, 80'h7a, 4'h0, 1'b0, 1'b0, 40'h0},
      '{1'b0, 1, 80'h75, 4'h4, 1'b0, 1'b1, 40'h0},
      '{1'b0, 1, 80'h75, 4'h0, 1'b0, 1'b1, 40'h0},
      '{1'b0, 1, 80'h7a, 4'h8, 1'b0, 1'b0, 40'h0},
      '{1'b0, 1, 80'h75, 4'h4, 1'b0, 1'b1, 40'h0},
      '{1'b0, 1, 80'h8a, 4'h8, 1'b0, 1'b0, 40'h0},
      '{1'b0, 1, 80'h75, 4'h4, 1'b0, 1'b1, 40'h0},
      '{1'b0, 1, 80'h30, 4'h8, 1'b0, 1'b0, 40'h0},
      '{1'b0, 5, 80'hfb123456a5, 4'h0, 1'b0, 1'b0, 40'h0},
      '{1'b1, 5, 80'hfb123456a5, 4'h2, 1'b0, 1'b0, 40'h00123456a5},
      '{1'b1, 6, 80'he189abcdef3c, 4'h2, 1'b0, 1'b0, 40'h89abcdef3c},
      '{1'b1, 3, 80'h2f3412, 4'h1, 1'b0, 1'b0, 40'h1234},
      '{1'b0, 3, 80'h2f5678, 4'h0, 1'b0, 1'b0, 40'h0},
      '{1'b0, 1, 80'h06, 4'h0, 1'b1, 1'b0, 40'h0},
      '{1'b0, 1, 80'h75, 4'h4, 1'b1, 1'b1, 40'h0}
    };
    rst_n = 1'b0;
    addr_4byte = 1'b0;
    op_busy = 1'b0;
    otp_wr_ready = 1'b0;
    clr = 1'b0;
    n_errors = 0;
    checks_done = 0;
    do_reset();
    @(posedge clk) op_busy <= 1'b1;
    foreach (rows[r])
    begin
      if (rows[r].wren)
        send(80'h06, 1, 0, 1'b0);
      send(rows[r].bytes, rows[r].n, 0, 1'b0);
      check("pulses", 40'(rows[r].pulses), 40'(seen));
      check("write_enabled", 40'(rows[r].we_after), 40'(write_enabled));
      check("op_suspended", 40'(rows[r].susp_after), 40'(op_suspended));
      if (rows[r].pulses[1])
        check("lock_wr", rows[r].val, 40'(lock_wr));
      if (rows[r].pulses[0])
        check("scheme_value", rows[r].val, 40'(scheme_value));
      $display("Row %0d done", r);
    end
    // Second reset with a suspended operation and write enable both set
    do_reset();
    @(posedge clk) op_busy <= 1'b0;
    send(80'h75, 1, 0, 1'b0);
    check("suspend when idle", 40'h0, 40'({seen, op_suspended}));
    rd_test(80'h6b001234, 4, 3, 1'b1, sfd_pkg::OP_ARRAY_RD, 32'h00001234);
    rd_test(80'h6ca1b2c3d4, 5, 3, 1'b1, sfd_pkg::OP_ARRAY_RD, 32'ha1b2c3d4);
    rd_test(80'h4b0003fe, 4, 3, 1'b0, sfd_pkg::OP_OTP_RD, 32'h000003fe);
    rd_test(80'hfa045678, 4, 1, 1'b0, sfd_pkg::OP_LOCK_RD, 32'h00045678);
    rd_test(80'he012345678, 5, 1, 1'b0, sfd_pkg::OP_LOCK_RD, 32'h12345678);
    otp_test(80'h420003fe112233445566, 10, 10'h3fe, 4, 32'h11223344);
    @(posedge clk) addr_4byte <= 1'b1;
    rd_test(80'h4b00000100, 5, 2, 1'b0, sfd_pkg::OP_OTP_RD, 32'h00000100);
    otp_test(80'h4200000010aabb, 7, 10'h010, 2, 32'haabb0000);
    stop_test();
  end

  initial
  begin
    #400us;
    n_errors++;
    $display("MISMATCH run time expected finish seen hang");
    stop_test();
  end
endmodule
